// ### hdl/cri_irq_status.sv
// What this block does
// [RULE1] Bit 7 follows valid USB supply
// [RULE2] Bit 6 follows valid wall supply
// [RULE3] Bit 5 flags thermal charge suspend
// [RULE4] Bit 4 flags termination current crossed
// [RULE5] Bits 3..1 flag taper, fast, precharge timeouts
// [RULE6] Bit 0 flags battery temperature out of range
// [RULE7] Host clears bits 4..1, restarting charger
// [RULE8] Unmasked charge status bit drives interrupt
// [RULE9] Regulator bit 7 flags power button request
// [RULE10] Regulator bit 5 flags supply undervoltage
// [RULE11] Regulator bit 4 always reads zero
// [RULE12] Bits 3,2 flag enabled linear regulator faults
// [RULE13] Bit 1 flags main converter out of regulation
// [RULE14] Bit 0 flags core fault or low-power setting
// [RULE15] New regulator event drives interrupt unless inhibited
// [RULE16] Charge inhibit bits gate, reset to ones
// [RULE17] Regulator inhibit bits gate, reset to ones
// [RULE18] Acknowledged bits leave the interrupt line
// [RULE19] Charge acknowledge clears with condition, read-only
// [RULE20] Regulator acknowledge behaves the same way
// [RULE21] Reading status acknowledges every bit read as one
// [RULE22] Charge bits 5,0 edge set, cleared after ack
// [RULE23] Regulator 7..5 edge set, 3..0 level
// [RULE24] Host address has a strapped low bit
// [RULE25] Open-drain interrupt low while anything pending
module cri_irq_status (
    input wire logic clk,
    input wire logic reset_n,
    input cri_pkg::cri_bus_req_t bus_req,
    output logic [7:0] rd_data_q,
    output logic rd_valid_q,
    input cri_pkg::cri_chg_src_t chg_pins,
    input cri_pkg::cri_reg_src_t reg_pins,
    input cri_pkg::cri_reg_ctl_t reg_ctl,
    output logic charger_reset_q,
    output logic int_out_q,
    output logic int_oe_q
);

    localparam int RAW_W = 15;

    logic [RAW_W-1:0] raw_pins;
    logic [RAW_W-1:0] pin_level;
    cri_pkg::cri_chg_src_t chg_lvl;
    cri_pkg::cri_reg_src_t reg_lvl;

    logic [7:0] chg_src;
    logic [7:0] reg_src;
    logic [7:0] chg_status;
    logic [7:0] chg_ack;
    logic [7:0] reg_status;
    logic [7:0] reg_ack;
    logic [7:0] reg_status_raw;
    logic [7:0] reg_ack_raw;

    logic [7:0] chg_inhibit_q;
    logic [7:0] chg_inhibit_d;
    logic [7:0] reg_inhibit_q;
    logic [7:0] reg_inhibit_d;
    logic [7:0] rd_data_d;
    logic rd_valid_d;
    logic charger_reset_d;
    logic int_oe_d;
    logic chg_read_hit;
    logic reg_read_hit;
    logic pending;

    // Conditions arrive from the analog side asynchronously to clk; the lid pin idles
    // high, so it enters inverted and a cleared synchroniser means lid closed, not an edge
    assign raw_pins = {chg_pins, reg_pins.power_button_request, ~reg_pins.battery_lid_input,
        reg_pins[4:0]};

    cri_sync #(
        .WIDTH(RAW_W)
    ) u_sync (
        .clk(clk),
        .reset_n(reset_n),
        .pin(raw_pins),
        .level_q(pin_level)
    );

    assign chg_lvl = pin_level[RAW_W-1:7];
    assign reg_lvl = pin_level[6:0];

    // Charge sources map one to one onto charge_status
    always_comb begin
        chg_src[7] = chg_lvl.usb_present; // [RULE1]
        chg_src[6] = chg_lvl.ac_present; // [RULE2]
        chg_src[5] = chg_lvl.thermal_suspend; // [RULE3]
        chg_src[4] = chg_lvl.term_current; // [RULE4]
        chg_src[3] = chg_lvl.taper_timeout; // [RULE5]
        chg_src[2] = chg_lvl.chg_timeout; // [RULE5]
        chg_src[1] = chg_lvl.prechg_timeout; // [RULE5]
        chg_src[0] = chg_lvl.batt_temp_error; // [RULE6]
    end

    // Regulator sources; a disabled linear regulator never reports a fault
    always_comb begin
        reg_src[7] = reg_lvl.power_button_request; // [RULE9]
        reg_src[6] = reg_lvl.battery_lid_input; // Already inverted: 1 while the lid pin is low
        reg_src[5] = reg_lvl.supply_undervoltage_flag; // [RULE10]
        reg_src[4] = 1'b0; // [RULE11]
        reg_src[3] = reg_lvl.linear_reg_two_fault & reg_ctl.linear_reg_two_en; // [RULE12]
        reg_src[2] = reg_lvl.linear_reg_one_fault & reg_ctl.linear_reg_one_en; // [RULE12]
        reg_src[1] = reg_lvl.main_converter_fault; // [RULE13]
        reg_src[0] = reg_lvl.core_converter_fault
            | (reg_ctl.core_converter_control_b7 & reg_ctl.low_power_mode); // [RULE14]
    end

    assign chg_read_hit = bus_req.rd && (bus_req.addr == cri_pkg::OFS_CHARGE_STATUS);
    assign reg_read_hit = bus_req.rd && (bus_req.addr == cri_pkg::OFS_REGULATOR_STATUS);

    // Charge status cells, one per bit
    cri_status_bit #(.EDGE_SET(cri_pkg::CHG_EDGE_SET[7])) u_chg_bit7 (
        .clk(clk),
        .reset_n(reset_n),
        .src(chg_src[7]),
        .read_hit(chg_read_hit), // [RULE21]
        .status_q(chg_status[7]),
        .ack_q(chg_ack[7])
    );
    cri_status_bit #(.EDGE_SET(cri_pkg::CHG_EDGE_SET[6])) u_chg_bit6 (
        .clk(clk),
        .reset_n(reset_n),
        .src(chg_src[6]),
        .read_hit(chg_read_hit), // [RULE21]
        .status_q(chg_status[6]),
        .ack_q(chg_ack[6])
    );
    cri_status_bit #(.EDGE_SET(cri_pkg::CHG_EDGE_SET[5])) u_chg_bit5 (
        .clk(clk),
        .reset_n(reset_n),
        .src(chg_src[5]),
        .read_hit(chg_read_hit), // [RULE21]
        .status_q(chg_status[5]),
        .ack_q(chg_ack[5])
    );
    cri_status_bit #(.EDGE_SET(cri_pkg::CHG_EDGE_SET[4])) u_chg_bit4 (
        .clk(clk),
        .reset_n(reset_n),
        .src(chg_src[4]),
        .read_hit(chg_read_hit), // [RULE21]
        .status_q(chg_status[4]),
        .ack_q(chg_ack[4])
    );
    cri_status_bit #(.EDGE_SET(cri_pkg::CHG_EDGE_SET[3])) u_chg_bit3 (
        .clk(clk),
        .reset_n(reset_n),
        .src(chg_src[3]),
        .read_hit(chg_read_hit), // [RULE21]
        .status_q(chg_status[3]),
        .ack_q(chg_ack[3])
    );
    cri_status_bit #(.EDGE_SET(cri_pkg::CHG_EDGE_SET[2])) u_chg_bit2 (
        .clk(clk),
        .reset_n(reset_n),
        .src(chg_src[2]),
        .read_hit(chg_read_hit), // [RULE21]
        .status_q(chg_status[2]),
        .ack_q(chg_ack[2])
    );
    cri_status_bit #(.EDGE_SET(cri_pkg::CHG_EDGE_SET[1])) u_chg_bit1 (
        .clk(clk),
        .reset_n(reset_n),
        .src(chg_src[1]),
        .read_hit(chg_read_hit), // [RULE21]
        .status_q(chg_status[1]),
        .ack_q(chg_ack[1])
    );
    cri_status_bit #(.EDGE_SET(cri_pkg::CHG_EDGE_SET[0])) u_chg_bit0 (
        .clk(clk),
        .reset_n(reset_n),
        .src(chg_src[0]),
        .read_hit(chg_read_hit), // [RULE21]
        .status_q(chg_status[0]),
        .ack_q(chg_ack[0])
    );

    // Regulator status cells; bit 4 has a constant-low source and is masked below
    cri_status_bit #(.EDGE_SET(cri_pkg::REG_EDGE_SET[7])) u_reg_bit7 (
        .clk(clk),
        .reset_n(reset_n),
        .src(reg_src[7]),
        .read_hit(reg_read_hit), // [RULE21]
        .status_q(reg_status_raw[7]),
        .ack_q(reg_ack_raw[7])
    );
    cri_status_bit #(.EDGE_SET(cri_pkg::REG_EDGE_SET[6])) u_reg_bit6 (
        .clk(clk),
        .reset_n(reset_n),
        .src(reg_src[6]),
        .read_hit(reg_read_hit), // [RULE21]
        .status_q(reg_status_raw[6]),
        .ack_q(reg_ack_raw[6])
    );
    cri_status_bit #(.EDGE_SET(cri_pkg::REG_EDGE_SET[5])) u_reg_bit5 (
        .clk(clk),
        .reset_n(reset_n),
        .src(reg_src[5]),
        .read_hit(reg_read_hit), // [RULE21]
        .status_q(reg_status_raw[5]),
        .ack_q(reg_ack_raw[5])
    );
    cri_status_bit #(.EDGE_SET(cri_pkg::REG_EDGE_SET[4])) u_reg_bit4 (
        .clk(clk),
        .reset_n(reset_n),
        .src(reg_src[4]),
        .read_hit(reg_read_hit), // [RULE21]
        .status_q(reg_status_raw[4]),
        .ack_q(reg_ack_raw[4])
    );
    cri_status_bit #(.EDGE_SET(cri_pkg::REG_EDGE_SET[3])) u_reg_bit3 (
        .clk(clk),
        .reset_n(reset_n),
        .src(reg_src[3]),
        .read_hit(reg_read_hit), // [RULE21]
        .status_q(reg_status_raw[3]),
        .ack_q(reg_ack_raw[3])
    );
    cri_status_bit #(.EDGE_SET(cri_pkg::REG_EDGE_SET[2])) u_reg_bit2 (
        .clk(clk),
        .reset_n(reset_n),
        .src(reg_src[2]),
        .read_hit(reg_read_hit), // [RULE21]
        .status_q(reg_status_raw[2]),
        .ack_q(reg_ack_raw[2])
    );
    cri_status_bit #(.EDGE_SET(cri_pkg::REG_EDGE_SET[1])) u_reg_bit1 (
        .clk(clk),
        .reset_n(reset_n),
        .src(reg_src[1]),
        .read_hit(reg_read_hit), // [RULE21]
        .status_q(reg_status_raw[1]),
        .ack_q(reg_ack_raw[1])
    );
    cri_status_bit #(.EDGE_SET(cri_pkg::REG_EDGE_SET[0])) u_reg_bit0 (
        .clk(clk),
        .reset_n(reset_n),
        .src(reg_src[0]),
        .read_hit(reg_read_hit), // [RULE21]
        .status_q(reg_status_raw[0]),
        .ack_q(reg_ack_raw[0])
    );

    // The missing bit is forced low so it can never reach the pin
    assign reg_status = reg_status_raw & cri_pkg::REG_IMPLEMENTED; // [RULE11]
    assign reg_ack = reg_ack_raw & cri_pkg::REG_IMPLEMENTED;

    // Register writes: inhibit registers store, a charge status write can restart the charger; acknowledge registers are read-only
    always_comb begin
        chg_inhibit_d = chg_inhibit_q;
        reg_inhibit_d = reg_inhibit_q;
        charger_reset_d = 1'b0;
        if (bus_req.wr) begin
            if (bus_req.addr == cri_pkg::OFS_CHARGE_STATUS) begin
                // Zero written over a set timeout or termination bit restarts the charger;
                // the bit itself drops once the charger lets its source fall
                charger_reset_d = |(chg_status & ~bus_req.wdata
                    & cri_pkg::CHG_HOST_CLEAR); // [RULE7]
            end else if (bus_req.addr == cri_pkg::OFS_CHARGE_EVENT_INHIBIT) begin
                chg_inhibit_d = bus_req.wdata; // [RULE16]
            end else if (bus_req.addr == cri_pkg::OFS_REGULATOR_EVENT_INHIBIT) begin
                reg_inhibit_d = bus_req.wdata; // [RULE17]
            end
        end
    end

    // Read data is latched in the read cycle, so later events are not lost
    always_comb begin
        rd_data_d = rd_data_q;
        rd_valid_d = bus_req.rd;
        if (bus_req.rd) begin
            if (bus_req.addr == cri_pkg::OFS_CHARGE_STATUS) begin
                rd_data_d = chg_status;
            end else if (bus_req.addr == cri_pkg::OFS_REGULATOR_STATUS) begin
                rd_data_d = reg_status;
            end else if (bus_req.addr == cri_pkg::OFS_CHARGE_EVENT_INHIBIT) begin
                rd_data_d = chg_inhibit_q;
            end else if (bus_req.addr == cri_pkg::OFS_REGULATOR_EVENT_INHIBIT) begin
                rd_data_d = reg_inhibit_q;
            end else if (bus_req.addr == cri_pkg::OFS_CHARGE_EVENT_ACKNOWLEDGED) begin
                rd_data_d = chg_ack; // [RULE19]
            end else if (bus_req.addr == cri_pkg::OFS_REGULATOR_EVENT_ACKNOWLEDGED) begin
                rd_data_d = reg_ack; // [RULE20]
            end else begin
                rd_data_d = cri_pkg::UNMAPPED_READ;
            end
        end
    end

    // Pin is pulled low while any unmasked, unacknowledged bit stands
    always_comb begin
        pending = |(chg_status & ~chg_inhibit_q & ~chg_ack) // [RULE8] [RULE18]
            | |(reg_status & ~reg_inhibit_q & ~reg_ack); // [RULE15] [RULE18]
        int_oe_d = pending; // [RULE25]
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            chg_inhibit_q <= cri_pkg::RST_INHIBIT;
            reg_inhibit_q <= cri_pkg::RST_INHIBIT;
            rd_data_q <= cri_pkg::RST_DATA;
            rd_valid_q <= 1'b0;
            charger_reset_q <= 1'b0;
            int_oe_q <= 1'b0;
            int_out_q <= 1'b0;
        end else begin
            chg_inhibit_q <= chg_inhibit_d;
            reg_inhibit_q <= reg_inhibit_d;
            rd_data_q <= rd_data_d;
            rd_valid_q <= rd_valid_d;
            charger_reset_q <= charger_reset_d;
            int_oe_q <= int_oe_d;
            // Open drain only ever pulls low
            int_out_q <= 1'b0;
        end
    end

endmodule

// ### hdl/cri_pkg.sv
package cri_pkg;

    localparam int DATA_W = 8;
    localparam int ADDR_W = 8;

    // Register offsets on the serial register port
    localparam logic [7:0] OFS_CHARGE_STATUS = 8'h01;
    localparam logic [7:0] OFS_REGULATOR_STATUS = 8'h02;
    localparam logic [7:0] OFS_CHARGE_EVENT_INHIBIT = 8'h03;
    localparam logic [7:0] OFS_REGULATOR_EVENT_INHIBIT = 8'h04;
    localparam logic [7:0] OFS_CHARGE_EVENT_ACKNOWLEDGED = 8'h05;
    localparam logic [7:0] OFS_REGULATOR_EVENT_ACKNOWLEDGED = 8'h06;

    // Values after reset
    localparam logic [7:0] RST_STATUS = 8'h00;
    localparam logic [7:0] RST_INHIBIT = 8'hFF;
    localparam logic [7:0] RST_ACK = 8'h00;
    localparam logic [7:0] RST_DATA = 8'h00;

    // Answer to an unlisted register
    localparam logic [7:0] UNMAPPED_READ = 8'hFF;

    // Bits set on a rising source edge; the rest follow their source level
    localparam logic [7:0] CHG_EDGE_SET = 8'h21;
    localparam logic [7:0] REG_EDGE_SET = 8'hE0;
    // Charge bits the host may clear, forcing a charger restart
    localparam logic [7:0] CHG_HOST_CLEAR = 8'h1E;
    // Regulator bit 4 does not exist
    localparam logic [7:0] REG_IMPLEMENTED = 8'hEF;

    // Synchroniser depth for pin inputs
    localparam int SYNC_STAGES = 3;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } cri_bus_req_t;

    // Charger conditions, in charge_status bit order (bit 7 first)
    typedef struct packed {
        logic usb_present;
        logic ac_present;
        logic thermal_suspend;
        logic term_current;
        logic taper_timeout;
        logic chg_timeout;
        logic prechg_timeout;
        logic batt_temp_error;
    } cri_chg_src_t;

    // Regulator condition pins
    typedef struct packed {
        logic power_button_request;
        logic battery_lid_input;
        logic supply_undervoltage_flag;
        logic linear_reg_two_fault;
        logic linear_reg_one_fault;
        logic main_converter_fault;
        logic core_converter_fault;
    } cri_reg_src_t;

    // Same-clock control bits from the converter and linear regulator registers
    typedef struct packed {
        logic linear_reg_two_en;
        logic linear_reg_one_en;
        logic core_converter_control_b7;
        logic low_power_mode;
    } cri_reg_ctl_t;

endpackage

// ### hdl/cri_status_bit.sv
module cri_status_bit #(
    parameter bit EDGE_SET = 1'b0
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic src,
    input wire logic read_hit,
    output logic status_q,
    output logic ack_q
);

    logic prev_q;
    logic status_d;
    logic ack_d;
    logic rise;

    always_comb begin
        rise = src & ~prev_q;
        if (EDGE_SET) begin
            // A new edge beats the release in the same cycle
            status_d = rise | (status_q & ~(~src & ack_q)); // [RULE22] [RULE23]
        end else begin
            status_d = src; // [RULE23]
        end
        // Read of a set bit acknowledges it; removal of the condition drops it
        ack_d = status_q & (ack_q | read_hit); // [RULE19] [RULE20] [RULE21]
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            prev_q <= 1'b0;
            status_q <= 1'b0;
            ack_q <= 1'b0;
        end else begin
            prev_q <= src;
            status_q <= status_d;
            ack_q <= ack_d;
        end
    end

endmodule

// ### hdl/cri_sync.sv
module cri_sync #(
    parameter int WIDTH = 8
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [WIDTH-1:0] pin,
    output logic [WIDTH-1:0] level_q
);

    logic [WIDTH-1:0] s1_q;
    logic [WIDTH-1:0] s2_q;
    logic [WIDTH-1:0] s3_q;
    logic [WIDTH-1:0] level_d;

    // A change counts only once the last two stages agree
    always_comb begin
        level_d = (s2_q & s3_q) | (level_q & (s2_q | s3_q));
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            level_q <= '0;
        end else begin
            s1_q <= pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
            level_q <= level_d;
        end
    end

endmodule

// ### testbench/cri_host.sv
module cri_host (
    input wire logic clk,
    input wire logic [7:0] rd_data_q,
    input wire logic rd_valid_q,
    output cri_pkg::cri_bus_req_t bus_req
);
    timeunit 1ns;
    timeprecision 1ps;
    // Address the absent serial engine answers: six fixed bits plus strap low
    localparam logic [6:0] DEV_ADDR = 7'h48;
    initial bus_req = '0;
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        bus_req <= {1'b0, 1'b1, a, d};
        @(posedge clk);
        bus_req.wr <= 1'b0;
    endtask
    // The read itself is the acknowledgment; a host write to an acknowledge register is ignored
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        int n;
        @(posedge clk);
        bus_req <= {1'b1, 1'b0, a, 8'h00};
        @(posedge clk);
        bus_req.rd <= 1'b0;
        #1;
        n = 0;
        while (rd_valid_q !== 1'b1 && n < 3) begin
            @(posedge clk);
            #1;
            n++;
        end
        // A missing answer poisons the data, so the caller's compare counts it
        d = (rd_valid_q === 1'b1) ? rd_data_q : 8'hXX;
    endtask
endmodule

// ### testbench/cri_irq_status_props.sv
module cri_irq_status_props (
    input wire logic clk,
    input wire logic reset_n,
    input wire cri_pkg::cri_bus_req_t bus_req,
    input wire logic [7:0] rd_data_q,
    input wire logic rd_valid_q,
    input wire cri_pkg::cri_chg_src_t chg_pins,
    input wire cri_pkg::cri_reg_src_t reg_pins,
    input wire cri_pkg::cri_reg_ctl_t reg_ctl,
    input wire logic charger_reset_q,
    input wire logic int_out_q,
    input wire logic int_oe_q
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    logic rd1, rd2, wr1;
    assign rd1 = bus_req.rd && bus_req.addr == 8'h01;
    assign rd2 = bus_req.rd && bus_req.addr == 8'h02;
    assign wr1 = bus_req.wr && bus_req.addr == 8'h01;
    a_read_answer: assert property (bus_req.rd |=> rd_valid_q)
        else $error("read not answered");
    a_valid_cause: assert property (rd_valid_q |-> $past(bus_req.rd))
        else $error("read answer without read");
    a_od_data_low: assert property (int_out_q == 1'b0)
        else $error("open-drain data not low");
    a_reg_bit_four: assert property (rd2 |=> !rd_data_q[4])
        else $error("regulator bit 4 read as one");
    a_restart_cause: assert property (charger_reset_q |-> $past(wr1))
        else $error("charger restart without write");
    a_restart_none: assert property (wr1 && bus_req.wdata[4:1] == 4'hF |=> !charger_reset_q)
        else $error("charger restart on all-ones write");
    a_usb_level: assert property (chg_pins.usb_present [*8] ##0 rd1 |=> rd_data_q[7])
        else $error("usb bit low while supply present");
    a_ac_level: assert property (!chg_pins.ac_present [*8] ##0 rd1 |=> !rd_data_q[6])
        else $error("wall bit high without supply");
    a_main_level: assert property (!reg_pins.main_converter_fault [*8] ##0 rd2 |=> !rd_data_q[1])
        else $error("main fault bit high in regulation");
    a_ldo_off: assert property (!reg_ctl.linear_reg_two_en [*8] ##0 rd2 |=> !rd_data_q[3])
        else $error("disabled regulator reports fault");
    c_irq: cover property ($rose(int_oe_q));
    c_restart: cover property (charger_reset_q);
    c_unmapped: cover property (bus_req.rd && bus_req.addr == 8'h07);
endmodule
bind cri_irq_status cri_irq_status_props u_props (.clk(clk), .reset_n(reset_n),
    .bus_req(bus_req), .rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q), .chg_pins(chg_pins),
    .reg_pins(reg_pins), .reg_ctl(reg_ctl), .charger_reset_q(charger_reset_q),
    .int_out_q(int_out_q), .int_oe_q(int_oe_q));

// ### testbench/tb_top.sv
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    cri_pkg::cri_bus_req_t bus_req;
    logic [7:0] rd_data_q;
    logic rd_valid_q, charger_reset_q, int_out_q, int_oe_q, int_pin_n;
    cri_pkg::cri_chg_src_t chg_pins = '0;
    cri_pkg::cri_reg_src_t reg_pins = 7'h20;
    cri_pkg::cri_reg_ctl_t reg_ctl = '0;
    int failures = 0;
    int num_checks = 0;
    // Pulled-up line: low only while the block enables its driver
    assign int_pin_n = int_oe_q ? 1'b0 : 1'b1;
    initial forever #12.5 clk = ~clk;
    cri_irq_status u_cri_irq_status (.clk(clk), .reset_n(reset_n), .bus_req(bus_req),
        .rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q), .chg_pins(chg_pins),
        .reg_pins(reg_pins), .reg_ctl(reg_ctl), .charger_reset_q(charger_reset_q),
        .int_out_q(int_out_q), .int_oe_q(int_oe_q));
    cri_host u_cri_host (.clk(clk), .rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q),
        .bus_req(bus_req));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        u_cri_host.rd(a, d);
        check(d, exp);
    endtask
    task automatic ck_int(input logic e);
        check({7'h00, int_pin_n}, {7'h00, e});
    endtask
    task automatic t_reset;
        logic [7:0] exp [8] = '{8'hFF, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'hFF};
        for (int a = 0; a < 8; a++) begin
            rdc(a[7:0], exp[a]);
        end
        ck_int(1'b1);
        $display("t_reset done");
    endtask
    task automatic t_chg;
        @(posedge clk) chg_pins.usb_present <= 1'b1;
        wt(8);
        ck_int(1'b1);
        u_cri_host.wr(8'h03, 8'h00);
        rdc(8'h03, 8'h00);
        ck_int(1'b0);
        rdc(8'h01, 8'h80);
        wt(2);
        ck_int(1'b1);
        u_cri_host.wr(8'h05, 8'h00);
        rdc(8'h05, 8'h80);
        @(posedge clk) chg_pins <= 8'h21;
        wt(8);
        ck_int(1'b0);
        @(posedge clk) chg_pins <= 8'h00;
        wt(8);
        rdc(8'h01, 8'h21);
        wt(2);
        ck_int(1'b1);
        rdc(8'h01, 8'h00);
        wt(2);
        rdc(8'h05, 8'h00);
        $display("t_chg done");
    endtask
    task automatic t_restart;
        @(posedge clk) chg_pins <= 8'h5E;
        wt(8);
        u_cri_host.wr(8'h01, 8'hFF);
        #1 check({7'h00, charger_reset_q}, 8'h00);
        u_cri_host.wr(8'h01, 8'hE1);
        #1 check({7'h00, charger_reset_q}, 8'h01);
        rdc(8'h01, 8'h5E);
        @(posedge clk) chg_pins <= 8'h00;
        wt(8);
        rdc(8'h01, 8'h00);
        $display("t_restart done");
    endtask
    task automatic t_reg;
        u_cri_host.wr(8'h04, 8'h00);
        @(posedge clk) reg_pins <= 7'h53;
        wt(8);
        ck_int(1'b0);
        rdc(8'h02, 8'hE3);
        wt(2);
        ck_int(1'b1);
        rdc(8'h06, 8'hE3);
        @(posedge clk) reg_pins <= 7'h20;
        wt(8);
        rdc(8'h02, 8'h00);
        wt(2);
        rdc(8'h06, 8'h00);
        $display("t_reg done");
    endtask
    task automatic t_ldo;
        u_cri_host.wr(8'h04, 8'hFF);
        @(posedge clk) reg_pins <= 7'h2C;
        wt(8);
        rdc(8'h02, 8'h00);
        @(posedge clk) reg_ctl <= 4'hF;
        wt(8);
        ck_int(1'b1);
        rdc(8'h02, 8'h0D);
        $display("t_ldo done");
    endtask
    task automatic final_report;
        $display("checks=%0d failures=%0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // Whole run is under two hundred cycles; this bound leaves ample margin
    initial begin
        #50us;
        failures++;
        final_report();
    end
    initial begin
        repeat (8) @(posedge clk);
        reset_n <= 1'b1;
        t_reset();
        t_chg();
        t_restart();
        t_reg();
        t_ldo();
        final_report();
    end
endmodule
